// ---- core/biaf_ack_store.v ----
// acknowledge byte storage with per-bit write mask
`default_nettype none
`include "biaf_consts.vh"

module biaf_ack_store (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // update from the register port
    input wire wr_en,
    input wire [7:0] wr_mask,
    input wire [7:0] wr_data,
    // stored byte
    output reg [7:0] ack_r
);

    wire [7:0] ack_nxt;

    // mask and data land in one edge, never half an update
    assign ack_nxt = (ack_r & ~wr_mask) | (wr_data & wr_mask); // [R02] [R12]

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_r <= `BIAF_ACK_RST; // [R03]
        end else if (wr_en) begin
            ack_r <= ack_nxt; // [R12]
        end
    end

endmodule // biaf_ack_store

`default_nettype wire

// ---- core/biaf_consts.vh ----
// constants shared by the boot info acknowledge and valid flag block
`ifndef BIAF_CONSTS_VH
`define BIAF_CONSTS_VH

// ***************************************************************
// register indices, byte address is four times the index
// ***************************************************************
`define BIAF_IDX_CLR 6'h03
`define BIAF_IDX_ACK 6'h04
`define BIAF_IDX_FLAGS 6'h05
`define BIAF_IDX_STAT 6'h06
`define BIAF_ADDR_LOW 2'h0

// ***************************************************************
// field positions
// ***************************************************************
`define BIAF_ACK_MASK_LSB 0
`define BIAF_ACK_DATA_LSB 8
`define BIAF_VALID_BIT 7
`define BIAF_CLR_PWR 0
`define BIAF_CLR_BTN 1
`define BIAF_CLR_WDT 2
`define BIAF_CLR_TMO 3
`define BIAF_CLR_PEF 4
`define BIAF_STAT_TMO_SEEN 0
`define BIAF_STAT_TMR_RUN 1

// ***************************************************************
// reset values
// ***************************************************************
`define BIAF_ACK_RST 8'h00
`define BIAF_FLAGS_RST 8'h00
`define BIAF_CLR_RST 5'h00
`define BIAF_RD_ZERO 32'h0000_0000
`define BIAF_MASK_RD 8'h00

// ***************************************************************
// timing
// ***************************************************************
`define BIAF_CLK_HZ 36'h0_0bebc200
`define BIAF_VALID_TMO_S 36'h0_0000003c
`define BIAF_TMO_CYC (`BIAF_VALID_TMO_S * `BIAF_CLK_HZ)

`endif

// ---- core/biaf_top.v ----
// boot info acknowledge byte and boot flags valid bit, register port top
//
// How it works
// R01 - the write mask of the acknowledge parameter is not stored and always reads as zero.
// R02 - each acknowledge bit whose mask bit is one takes the written data, the rest keep.
// R03 - the acknowledge byte clears to zero on controller reset or power-up.
// R04 - the boot starter normally loads all ones into the acknowledge byte before a boot.
// R05 - the boot starter may write zeros to chosen bits so those consumers ignore the info.
// R06 - writers put ones in acknowledge bits 7 to 5 and readers ignore those bits.
// R07 - a zero in acknowledge bits 4 to 0 means vendor, sms, system_loader or self-test is done.
// R08 - each consumer reads the boot options and then clears only its own bit.
// R09 - bit 7 of the first boot flags byte is the valid bit, set by software and held.
// R10 - the device may clear the valid bit itself as the clearing parameter selects.
// R11 - unless clearing bit 3 is set, no chassis command for 60 s clears the valid bit.
// R12 - mask and data of one acknowledge write are applied together as one update.
//
// Our own choice: the address-and-strobe port.
`default_nettype none
`include "biaf_consts.vh"

module biaf_top #(
    parameter [35:0] VALID_TMO_CYC = `BIAF_TMO_CYC,
    parameter AW = 8
) (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // register port
    input wire [AW-1:0] addr,
    input wire [31:0] wr_data,
    input wire wr_en,
    input wire rd_en,
    output reg [31:0] rd_data,
    // chassis control command seen, one-cycle pulse on clk
    input wire chassis_cmd,
    // reset causes from the platform, asynchronous levels
    input wire pwr_up_evt,
    input wire btn_reset_evt,
    input wire wdt_reset_evt,
    input wire pef_reset_evt,
    // state for the rest of the controller
    output reg boot_valid,
    output reg [7:0] boot_ack
);

    // ***************************************************************
    // address decode
    // ***************************************************************
    wire [AW-3:0] word_idx;
    wire word_aligned;
    wire sel_clr;
    wire sel_ack;
    wire sel_flags;
    wire sel_stat;

    assign word_idx = addr[AW-1:2];
    assign word_aligned = (addr[1:0] == `BIAF_ADDR_LOW);

    assign sel_clr = word_aligned && (word_idx == `BIAF_IDX_CLR);
    assign sel_ack = word_aligned && (word_idx == `BIAF_IDX_ACK);
    assign sel_flags = word_aligned && (word_idx == `BIAF_IDX_FLAGS);
    assign sel_stat = word_aligned && (word_idx == `BIAF_IDX_STAT);

    wire wr_clr;
    wire wr_ack;
    wire wr_flags;
    wire wr_stat;

    assign wr_clr = wr_en && sel_clr;
    assign wr_ack = wr_en && sel_ack;
    assign wr_flags = wr_en && sel_flags;
    assign wr_stat = wr_en && sel_stat;

    // ***************************************************************
    // reset cause synchronisers
    // ***************************************************************
    // order: power-up, button, watchdog, event filter
    wire [3:0] evt_raw;
    reg [3:0] evt_s1_r;
    reg [3:0] evt_s2_r;
    reg [3:0] evt_s3_r;
    wire [3:0] evt_rise;

    assign evt_raw = {pef_reset_evt, wdt_reset_evt, btn_reset_evt, pwr_up_evt};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_evt_sync
            always @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    evt_s1_r[gi] <= 1'b0;
                    evt_s2_r[gi] <= 1'b0;
                    evt_s3_r[gi] <= 1'b0;
                end else begin
                    evt_s1_r[gi] <= evt_raw[gi];
                    evt_s2_r[gi] <= evt_s1_r[gi];
                    evt_s3_r[gi] <= evt_s2_r[gi];
                end
            end
            // edge taken from the second and third stages
            assign evt_rise[gi] = evt_s2_r[gi] && !evt_s3_r[gi];
        end
    endgenerate

    // ***************************************************************
    // valid bit clearing parameter
    // ***************************************************************
    reg [4:0] clr_cfg_r;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            clr_cfg_r <= `BIAF_CLR_RST;
        end else if (wr_clr) begin
            clr_cfg_r <= wr_data[4:0];
        end
    end

    // ***************************************************************
    // acknowledge byte
    // ***************************************************************
    wire [7:0] ack_q;

    // reserved bits 7..5 are stored as written; software is told to
    // keep them at one and to ignore them on read [R06]
    biaf_ack_store u_ack (
        .clk(clk),
        .rst_b(rst_b),
        .wr_en(wr_ack),
        .wr_mask(wr_data[`BIAF_ACK_MASK_LSB +: 8]),
        .wr_data(wr_data[`BIAF_ACK_DATA_LSB +: 8]),
        .ack_r(ack_q)
    );

    // ***************************************************************
    // chassis command timeout
    // ***************************************************************
    reg [7:0] flags_r;
    wire tmr_run;
    wire tmr_restart;
    wire tmr_expire;
    wire tmr_busy;

    // countdown only matters while the flags claim to be valid
    assign tmr_run = flags_r[`BIAF_VALID_BIT] && !clr_cfg_r[`BIAF_CLR_TMO]; // [R11]
    assign tmr_restart = chassis_cmd || wr_flags; // [R11]

    biaf_valid_timer #(
        .TMO_CYC(VALID_TMO_CYC)
    ) u_tmr (
        .clk(clk),
        .rst_b(rst_b),
        .run(tmr_run),
        .restart(tmr_restart),
        .expire_r(tmr_expire),
        .busy_r(tmr_busy)
    );

    // ***************************************************************
    // automatic clearing of the valid bit
    // ***************************************************************
    wire clr_by_pwr;
    wire clr_by_btn;
    wire clr_by_wdt;
    wire clr_by_pef;
    wire auto_clr;

    assign clr_by_pwr = evt_rise[0] && !clr_cfg_r[`BIAF_CLR_PWR]; // [R10]
    assign clr_by_btn = evt_rise[1] && !clr_cfg_r[`BIAF_CLR_BTN]; // [R10]
    assign clr_by_wdt = evt_rise[2] && !clr_cfg_r[`BIAF_CLR_WDT]; // [R10]
    assign clr_by_pef = evt_rise[3] && !clr_cfg_r[`BIAF_CLR_PEF]; // [R10]

    assign auto_clr = tmr_expire || clr_by_pwr || clr_by_btn || clr_by_wdt || clr_by_pef;

    // ***************************************************************
    // first boot flags byte
    // ***************************************************************
    reg [7:0] flags_nxt;

    // a software write wins over a same-cycle automatic clear
    always @* begin
        flags_nxt = flags_r;
        if (wr_flags) begin
            flags_nxt = wr_data[7:0]; // [R09]
        end else if (auto_clr) begin
            flags_nxt[`BIAF_VALID_BIT] = 1'b0; // [R10] [R11]
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_r <= `BIAF_FLAGS_RST;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // ***************************************************************
    // status: sticky timeout flag, write one to clear
    // ***************************************************************
    reg tmo_seen_r;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tmo_seen_r <= 1'b0;
        end else if (tmr_expire) begin
            // set beats clear so an expiry is never lost
            tmo_seen_r <= 1'b1;
        end else if (wr_stat && wr_data[`BIAF_STAT_TMO_SEEN]) begin
            tmo_seen_r <= 1'b0;
        end
    end

    // ***************************************************************
    // read mux
    // ***************************************************************
    reg [31:0] rd_mux;

    always @* begin
        rd_mux = `BIAF_RD_ZERO;
        if (sel_clr) begin
            rd_mux[4:0] = clr_cfg_r;
        end else if (sel_ack) begin
            rd_mux[`BIAF_ACK_MASK_LSB +: 8] = `BIAF_MASK_RD; // [R01]
            rd_mux[`BIAF_ACK_DATA_LSB +: 8] = ack_q; // [R07]
        end else if (sel_flags) begin
            rd_mux[7:0] = flags_r; // [R09]
        end else if (sel_stat) begin
            rd_mux[`BIAF_STAT_TMO_SEEN] = tmo_seen_r;
            rd_mux[`BIAF_STAT_TMR_RUN] = tmr_busy;
        end
    end

    // read data stand only in the cycle after the strobe
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= `BIAF_RD_ZERO;
        end else if (rd_en) begin
            rd_data <= rd_mux;
        end else begin
            rd_data <= `BIAF_RD_ZERO;
        end
    end

    // ***************************************************************
    // registered state outputs
    // ***************************************************************
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            boot_valid <= 1'b0;
            boot_ack <= `BIAF_ACK_RST;
        end else begin
            boot_valid <= flags_nxt[`BIAF_VALID_BIT];
            boot_ack <= wr_ack ? ((ack_q & ~wr_data[`BIAF_ACK_MASK_LSB +: 8])
                | (wr_data[`BIAF_ACK_DATA_LSB +: 8] & wr_data[`BIAF_ACK_MASK_LSB +: 8]))
                : ack_q; // [R02]
        end
    end

endmodule // biaf_top

`default_nettype wire

// ---- core/biaf_valid_timer.v ----
// countdown that expires when no chassis command arrives in time
`default_nettype none
`include "biaf_consts.vh"

module biaf_valid_timer #(
    parameter [35:0] TMO_CYC = `BIAF_TMO_CYC
) (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // control
    input wire run,
    input wire restart,
    // result
    output reg expire_r,
    output reg busy_r
);

    reg [35:0] cnt_r;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= 36'h0_00000000;
            expire_r <= 1'b0;
            busy_r <= 1'b0;
        end else if (!run) begin
            // idle: hold a full count ready for the next start
            cnt_r <= TMO_CYC;
            expire_r <= 1'b0;
            busy_r <= 1'b0;
        end else if (restart || !busy_r) begin
            cnt_r <= TMO_CYC; // [R11]
            expire_r <= 1'b0;
            busy_r <= 1'b1;
        end else if (cnt_r <= 36'h0_00000001) begin
            cnt_r <= TMO_CYC;
            expire_r <= 1'b1; // [R11]
            busy_r <= 1'b1;
        end else begin
            cnt_r <= cnt_r - 36'h0_00000001;
            expire_r <= 1'b0;
            busy_r <= 1'b1;
        end
    end

endmodule // biaf_valid_timer

`default_nettype wire

// ---- tb/biaf_top_props.sv ----
// assertions on the ports of the acknowledge and valid flag block
`default_nettype none
module biaf_top_props #(
    parameter AW = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire logic [AW-1:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] rd_data,
    // outputs to the controller
    input wire logic boot_valid,
    input wire logic [7:0] boot_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    // ***************************************************************
    // decode helpers
    // ***************************************************************
    wire logic ack_wr = wr_en && (addr == 8'h10);
    wire logic ack_rd = rd_en && (addr == 8'h10);
    wire logic flags_wr = wr_en && (addr == 8'h14);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ***************************************************************
    // properties
    // ***************************************************************
    a_mask_reads_zero: assert property (ack_rd |=> rd_data[7:0] == 8'h00)
        else $error("mask byte read not zero");
    a_ack_masked_update: assert property (ack_wr |=> boot_ack ==
        (($past(boot_ack) & ~$past(wr_data[7:0])) | ($past(wr_data[15:8]) & $past(wr_data[7:0]))))
        else $error("ack masked update wrong");
    // reset check must run while reset is low, so no disable here
    a_ack_reset_zero: assert property (disable iff (1'b0) !rst_b |-> boot_ack == 8'h00)
        else $error("ack not zero in reset");
    a_ack_read_back: assert property (ack_rd |=> rd_data[15:8] == $past(boot_ack))
        else $error("ack read back wrong");
    a_ack_holds_idle: assert property (!ack_wr |=> $stable(boot_ack))
        else $error("ack changed without write");
    a_valid_tracks_wr: assert property (flags_wr |=> boot_valid == $past(wr_data[7]))
        else $error("valid bit not stored");
    a_valid_rise_sw: assert property ($rose(boot_valid) |-> $past(flags_wr))
        else $error("valid set without write");
    a_rd_idle_zero: assert property (!rd_en |=> rd_data == 32'h0000_0000)
        else $error("read data not idle zero");
    c_ack_write: cover property (ack_wr);
    c_ack_read: cover property (ack_rd);
    c_valid_set: cover property ($rose(boot_valid));
    c_valid_clear: cover property ($fell(boot_valid));
endmodule // biaf_top_props
`default_nettype wire

// ---- tb/test_biaf_top.sv ----
// self-checking bench for the acknowledge and valid flag block
`default_nettype none
module test_biaf_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TMO = 20;
    logic clk, rst_b, wr_en, rd_en, chassis_cmd, boot_valid;
    logic [7:0] addr, boot_ack, ack_exp;
    logic [31:0] wr_data, rd_data, d;
    logic [3:0] ev;
    int fail_count = 0;
    int checked = 0;
    biaf_top #(.VALID_TMO_CYC(36'(TMO)), .AW(8)) biaf_top_inst (.clk(clk), .rst_b(rst_b),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .chassis_cmd(chassis_cmd), .pwr_up_evt(ev[0]), .btn_reset_evt(ev[1]),
        .wdt_reset_evt(ev[2]), .pef_reset_evt(ev[3]), .boot_valid(boot_valid),
        .boot_ack(boot_ack));
    always #2.5 clk = ~clk;
    // ***************************************************************
    // bus and check tasks
    // ***************************************************************
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a; wr_data <= v; wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask
    // data stands only in the cycle after the strobe
    task rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a; rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 v = rd_data;
    endtask
    task ack_wr(input logic [7:0] m, input logic [7:0] v);
        wr(8'h10, {16'h0000, v, m});
        ack_exp = (ack_exp & ~m) | (v & m);
        chk(boot_ack, ack_exp, "boot_ack");
    endtask
    task ev_pulse(input int i);
        @(posedge clk) ev[i] <= 1'b1;
        repeat (4) @(posedge clk);
        ev[i] <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ***************************************************************
    // scenarios
    // ***************************************************************
    task t_ack;
        rd(8'h10, d);
        chk(d, 32'h0000_0000, "ack after reset");
        ack_exp = 8'h00;
        ack_wr(8'hff, 8'hff);
        rd(8'h10, d);
        chk(d, 32'h0000_ff00, "ack read with mask");
        for (int i = 0; i < 5; i++) ack_wr(8'h01 << i, 8'h00);
        ack_wr(8'h00, 8'h1f);
        ack_wr(8'ha5, 8'hef);
        rd(8'h10, d);
        chk(d, {16'h0000, ack_exp, 8'h00}, "ack read");
        rd(8'h20, d);
        chk(d, 32'h0000_0000, "unmapped read");
        rd(8'h11, d);
        chk(d, 32'h0000_0000, "unaligned read");
        wr(8'h20, 32'hffff_ffff);
        chk(boot_ack, ack_exp, "ack after unmapped write");
    endtask
    task t_timeout;
        wr(8'h14, 32'h0000_0080);
        chk(boot_valid, 1'b1, "valid set");
        rd(8'h14, d);
        chk(d, 32'h0000_0080, "flags read");
        repeat (6) begin
            repeat (TMO / 2) @(posedge clk);
            chassis_cmd <= 1'b1;
            @(posedge clk) chassis_cmd <= 1'b0;
        end
        #1 chk(boot_valid, 1'b1, "valid kept by commands");
        repeat (2 * TMO) @(posedge clk);
        #1 chk(boot_valid, 1'b0, "valid after timeout");
        rd(8'h18, d);
        chk(d, 32'h0000_0001, "timeout seen, timer stopped");
        wr(8'h18, 32'h0000_0001);
        rd(8'h18, d);
        chk(d, 32'h0000_0000, "timeout seen cleared");
        wr(8'h0c, 32'h0000_0008);
        wr(8'h14, 32'h0000_0080);
        repeat (2 * TMO) @(posedge clk);
        #1 chk(boot_valid, 1'b1, "timeout masked");
    endtask
    // timeout stays masked so only reset causes can clear the bit
    task t_causes;
        int b;
        for (int i = 0; i < 4; i++) begin
            b = (i == 3) ? 4 : i;
            wr(8'h0c, 32'h0000_0008 | (32'h1 << b));
            wr(8'h14, 32'h0000_0080);
            ev_pulse(i);
            chk(boot_valid, 1'b1, "cause masked");
            wr(8'h0c, 32'h0000_0008);
            ev_pulse(i);
            chk(boot_valid, 1'b0, "cause clears");
        end
    endtask
    task t_rereset;
        ack_wr(8'hff, 8'hff);
        @(posedge clk) rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(boot_ack, 8'h00, "ack after second reset");
        @(posedge clk) rst_b <= 1'b1;
    endtask
    initial begin
        clk = 0; rst_b = 0; addr = 0; wr_data = 0; wr_en = 0; rd_en = 0;
        chassis_cmd = 0; ev = 0; ack_exp = 0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        t_ack();
        t_timeout();
        t_causes();
        t_rereset();
        end_sim();
    end
    initial begin
        #20000;
        fail_count++;
        end_sim();
    end
endmodule // test_biaf_top
bind biaf_top biaf_top_props #(.AW(AW)) biaf_top_props_inst (.clk(clk), .rst_b(rst_b),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .boot_valid(boot_valid), .boot_ack(boot_ack));
`default_nettype wire
